//--- design/der_pkg.sv
// constants and types shared by the debug event response logic
package der_pkg;
  localparam int ADDR_W = 44;
  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CYCLE = 44'h085_0000_0100;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 44'h085_0000_0108;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 44'h085_0000_0110;
  localparam logic [ADDR_W-1:0] OFS_TALLY = 44'h85000000118;
  // control field positions
  localparam int CTL_W = 4;
  localparam int CTL_SOFT_ALL = 3;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_ACT_LO = 0;
  localparam int TRIG_BIT = 0;
  // action codes with the enable bit set
  localparam logic [1:0] ACT_WATCH = 2'h0;
  localparam logic [1:0] ACT_HARD = 2'h1;
  localparam logic [1:0] ACT_STRETCH = 2'h2;
  localparam logic [1:0] ACT_STR_HARD = 2'h3;
  // values after reset
  localparam logic [31:0] TALLY_RST = 32'h0000_0000;
  localparam logic [63:0] CYCLE_RST = 64'h0000_0000_0000_0000;
  localparam logic [CTL_W-1:0] CTRL_RST = 4'h0;
  // tally weights per request source
  localparam logic [31:0] CORE_WEIGHT = 32'h0000_0001;
  localparam logic [31:0] SYS_WEIGHT = 32'h0000_0004;
  // reset countdown sequencer
  typedef enum logic [1:0] {
    RC_IDLE = 2'b00,
    RC_LOW = 2'b01,
    RC_HIGH = 2'b10,
    RC_DONE = 2'b11
  } der_rc_state_t;
endpackage

//--- design/der_sync2.sv
// two-stage synchroniser for a pin level
`timescale 1ns/1ps
module der_sync2 (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stab;
  } der_sync_t;

  der_sync_t s_q;
  der_sync_t s_d;

  // first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.meta = din;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stab;
endmodule

//--- design/der_top.sv
// debug event response: event tally, cycle delay, reset countdown, trigger
`timescale 1ns/1ps
module der_top #(
  parameter int NUM_CORES = 8,
  parameter int DELAY_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic por_done,
  input wire logic [NUM_CORES-1:0] core_soft_req,
  input wire logic [NUM_CORES-1:0] core_hard_req,
  input wire logic [NUM_CORES-1:0] core_watch_req,
  input wire logic sys_hard_req,
  input wire logic sys_watch_req,
  input wire logic [NUM_CORES-1:0] strand_quiesced,
  input wire logic external_trigger_input,
  input wire logic [DELAY_W-1:0] ext_stop_delay,
  input wire logic [NUM_CORES-1:0] ext_domain_stop,
  input wire logic jtag_load_event_tally,
  input wire logic jtag_load_cycle_count,
  input wire logic jtag_load_response_control,
  input wire logic [63:0] jtag_data,
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic [der_pkg::ADDR_W-1:0] csr_addr,
  input wire logic [63:0] csr_wdata,
  output logic [63:0] csr_rdata,
  output logic csr_rvalid,
  output logic [NUM_CORES-1:0] strand_running,
  output logic [NUM_CORES-1:0] core_clk_stop,
  output logic chip_clk_stop,
  output logic clock_stretch,
  output logic trigger_out
);
  typedef struct packed {
    logic [31:0] tally;
    logic [63:0] cyc;
    logic [der_pkg::CTL_W-1:0] ctl;
    logic armed;
    logic pend_hard;
    logic pend_soft;
    logic pend_watch;
    logic [NUM_CORES-1:0] pend_cores;
    der_pkg::der_rc_state_t rc;
    logic ext_prev;
    logic ext_busy;
    logic [DELAY_W-1:0] ext_cnt;
    logic [NUM_CORES-1:0] ext_dom;
    logic hard;
    logic [NUM_CORES-1:0] dom_stop;
    logic [NUM_CORES-1:0] soft_cores;
    logic [NUM_CORES-1:0] run;
    logic [NUM_CORES-1:0] stop;
    logic stretch;
    logic trig;
    logic [63:0] rdata;
    logic rvalid;
  } der_state_t;

  der_state_t s_q;
  der_state_t s_d;
  logic ext_s;

  // pin crossing for the external trigger
  der_sync2 u_ext_sync (
    .clk(clk),
    .reset(reset),
    .din(external_trigger_input),
    .dout(ext_s)
  );

  // per-request decode
  logic [NUM_CORES-1:0] core_any;
  logic sys_any;
  logic [31:0] dec_amt;
  logic any_req;
  logic delayed_req;
  logic sel_tally;
  logic sel_cycle;
  logic sel_ctrl;
  logic sel_trig;

  assign core_any = core_soft_req | core_hard_req | core_watch_req;
  assign sys_any = sys_hard_req | sys_watch_req;
  assign any_req = (|core_any) | sys_any;
  // core requests and system hard stops wait
  assign delayed_req = (|core_any) | sys_hard_req;

  assign sel_tally = csr_addr == der_pkg::OFS_TALLY;
  assign sel_cycle = csr_addr == der_pkg::OFS_CYCLE;
  assign sel_ctrl = csr_addr == der_pkg::OFS_CTRL;
  assign sel_trig = csr_addr == der_pkg::OFS_TRIG;

  always_comb begin
    dec_amt = '0;
    for (int i = 0; i < NUM_CORES; i++) begin
      if (core_any[i]) begin
        dec_amt = dec_amt + der_pkg::CORE_WEIGHT;
      end
    end
    if (sys_any) begin
      dec_amt = dec_amt + der_pkg::SYS_WEIGHT;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    logic en;
    logic soft_all;
    logic [1:0] act;
    en = 1'b0;
    soft_all = 1'b0;
    act = 2'h0;
    s_d = s_q;
    en = s_q.ctl[der_pkg::CTL_ENABLE];
    soft_all = s_q.ctl[der_pkg::CTL_SOFT_ALL];
    act = s_q.ctl[der_pkg::CTL_ACT_LO +: 2];
    // pulses default low
    s_d.trig = 1'b0;
    s_d.stretch = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.ext_prev = ext_s;

    if (!en) begin
      s_d.rc = der_pkg::RC_IDLE;
      if (s_q.armed) begin
        // count down each cycle until zero
        if (s_q.cyc != 64'h0) begin
          s_d.cyc = s_q.cyc - 64'h1;
        end else begin
          s_d.armed = 1'b0;
          // a pending hard stop halts every domain
          if (s_q.pend_hard) begin
            s_d.hard = 1'b1;
            s_d.dom_stop = '1;
          end
          // bit3 widens soft stop to all cores
          if (s_q.pend_soft) begin
            s_d.soft_cores = s_q.soft_cores | (soft_all ? '1 : s_q.pend_cores);
          end
          if (s_q.pend_watch) begin
            s_d.trig = 1'b1;
          end
          s_d.pend_hard = 1'b0;
          s_d.pend_soft = 1'b0;
          s_d.pend_watch = 1'b0;
          s_d.pend_cores = '0;
        end
      end
      // tally counts only with enable clear
      if (any_req && s_q.tally != 32'h0) begin
        if (s_q.tally > dec_amt) begin
          s_d.tally = s_q.tally - dec_amt;
        end else begin
          s_d.tally = 32'h0;
        end
      end else if (any_req) begin
        // tally empty: a core request or system hard stop arms the delay
        if (delayed_req) begin
          s_d.armed = 1'b1;
        end
        s_d.pend_hard = s_d.pend_hard | (|core_hard_req) | sys_hard_req;
        s_d.pend_soft = s_d.pend_soft | (|core_soft_req);
        s_d.pend_watch = s_d.pend_watch | (|core_watch_req);
        s_d.pend_cores = s_d.pend_cores | core_soft_req;
        // system watchpoints are passed straight out
        if (sys_watch_req) begin
          s_d.trig = 1'b1;
        end
      end
    end else begin
      s_d.armed = 1'b0;
      s_d.pend_hard = 1'b0;
      s_d.pend_soft = 1'b0;
      s_d.pend_watch = 1'b0;
      s_d.pend_cores = '0;
      case (s_q.rc)
        der_pkg::RC_IDLE: begin
          if (por_done) begin
            s_d.rc = der_pkg::RC_LOW;
          end
        end
        der_pkg::RC_LOW: begin
          if (s_q.cyc[31:0] != 32'h0) begin
            s_d.cyc[31:0] = s_q.cyc[31:0] - 32'h1;
          end else begin
            // every action code pulses the trigger
            s_d.trig = 1'b1;
            s_d.rc = der_pkg::RC_DONE;
            case (act)
              der_pkg::ACT_HARD: begin
                s_d.hard = 1'b1;
                s_d.dom_stop = '1;
              end
              der_pkg::ACT_STRETCH: begin
                s_d.stretch = 1'b1;
              end
              der_pkg::ACT_STR_HARD: begin
                s_d.stretch = 1'b1;
                s_d.rc = der_pkg::RC_HIGH;
              end
              default: begin
                s_d.rc = der_pkg::RC_DONE;
              end
            endcase
          end
        end
        der_pkg::RC_HIGH: begin
          if (s_q.cyc[63:32] != 32'h0) begin
            s_d.cyc[63:32] = s_q.cyc[63:32] - 32'h1;
          end else begin
            s_d.trig = 1'b1;
            s_d.hard = 1'b1;
            s_d.dom_stop = '1;
            s_d.rc = der_pkg::RC_DONE;
          end
        end
        default: begin
          s_d.rc = der_pkg::RC_DONE;
        end
      endcase
    end

    if (ext_s && !s_q.ext_prev && !s_q.ext_busy) begin
      s_d.ext_busy = 1'b1;
      s_d.ext_cnt = ext_stop_delay;
      s_d.ext_dom = ext_domain_stop;
    end else if (s_q.ext_busy) begin
      if (s_q.ext_cnt != '0) begin
        s_d.ext_cnt = s_q.ext_cnt - 1'b1;
      end else begin
        s_d.ext_busy = 1'b0;
        s_d.hard = 1'b1;
        s_d.dom_stop = s_d.dom_stop | s_q.ext_dom;
      end
    end

    // soft stop drops running, clocks wait
    s_d.run = ~s_d.soft_cores;
    for (int i = 0; i < NUM_CORES; i++) begin
      // hard stop does not wait for cores
      s_d.stop[i] = s_q.dom_stop[i] | (s_q.soft_cores[i] & strand_quiesced[i]);
    end

    // software writes, after hardware updates
    if (csr_wr) begin
      if (sel_tally) begin
        s_d.tally = csr_wdata[31:0];
      end
      if (sel_cycle) begin
        s_d.cyc = csr_wdata;
      end
      if (sel_ctrl) begin
        s_d.ctl = csr_wdata[der_pkg::CTL_W-1:0];
      end
      if (sel_trig && csr_wdata[der_pkg::TRIG_BIT]) begin
        s_d.trig = 1'b1;
      end
    end

    if (jtag_load_event_tally) begin
      s_d.tally = jtag_data[31:0];
    end
    // jtag load of the cycle counter
    if (jtag_load_cycle_count) begin
      s_d.cyc = jtag_data;
    end
    // jtag load of the control register
    if (jtag_load_response_control) begin
      s_d.ctl = jtag_data[der_pkg::CTL_W-1:0];
    end

    // read answer one cycle later, unmapped reads zero
    if (csr_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 64'h0;
      if (sel_tally) begin
        s_d.rdata = {32'h0, s_q.tally};
      end
      if (sel_cycle) begin
        s_d.rdata = s_q.cyc;
      end
      if (sel_ctrl) begin
        s_d.rdata = {60'h0, s_q.ctl};
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.tally <= der_pkg::TALLY_RST;
      s_q.cyc <= der_pkg::CYCLE_RST;
      s_q.ctl <= der_pkg::CTRL_RST;
      s_q.rc <= der_pkg::RC_IDLE;
      s_q.run <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign csr_rdata = s_q.rdata;
  assign csr_rvalid = s_q.rvalid;
  assign strand_running = s_q.run;
  assign core_clk_stop = s_q.stop;
  assign chip_clk_stop = s_q.hard;
  assign clock_stretch = s_q.stretch;
  assign trigger_out = s_q.trig;
endmodule

//--- verification/der_req_model.sv
// far side: cores and system blocks raising debug requests
`timescale 1ns/1ps
module der_req_model #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [N-1:0] sel,
  input wire logic [N-1:0] strand_running,
  output logic [N-1:0] core_soft_req,
  output logic [N-1:0] core_hard_req,
  output logic [N-1:0] core_watch_req,
  output logic sys_hard_req,
  output logic sys_watch_req,
  output logic [N-1:0] strand_quiesced
);
  logic [N-1:0] q1 = '0;
  logic [N-1:0] q2 = '0;
  logic [N-1:0] q3 = '0;
  assign core_soft_req = (go && kind == 3'h0) ? sel : '0;
  assign core_hard_req = (go && kind == 3'h1) ? sel : '0;
  assign core_watch_req = (go && kind == 3'h2) ? sel : '0;
  assign sys_hard_req = go && kind == 3'h3;
  assign sys_watch_req = go && kind == 3'h4;
  assign strand_quiesced = q3;
  // strands settle three cycles after running drops
  always @(posedge clk) begin
    q1 <= ~strand_running;
    q2 <= q1;
    q3 <= q2;
  end
endmodule

//--- verification/der_top_checker.sv
// port assertions for the debug event response block
`timescale 1ns/1ps
module der_top_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic [der_pkg::ADDR_W-1:0] csr_addr,
  input wire logic [63:0] csr_wdata,
  input wire logic [63:0] csr_rdata,
  input wire logic csr_rvalid,
  input wire logic chip_clk_stop,
  input wire logic clock_stretch,
  input wire logic trigger_out,
  input wire logic external_trigger_input
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_trig_one;
    trigger_out |=> !trigger_out;
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger pulse too long");
  property p_sw_trig;
    csr_wr && csr_addr == der_pkg::OFS_TRIG && csr_wdata[0] |=> trigger_out ##1 !trigger_out;
  endproperty
  a_sw_trig: assert property (p_sw_trig) else $error("no software trigger pulse");
  property p_stretch_one;
    clock_stretch |=> !clock_stretch;
  endproperty
  a_stretch_one: assert property (p_stretch_one) else $error("stretch too long");
  property p_chip_sticky;
    chip_clk_stop |=> chip_clk_stop;
  endproperty
  a_chip_sticky: assert property (p_chip_sticky) else $error("chip stop released");
  property p_rd_valid;
    csr_rd |=> csr_rvalid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_ctrl_rd;
    csr_rd && csr_addr == der_pkg::OFS_CTRL |=> csr_rdata[63:4] == 60'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control upper bits set");
  property p_reset_vals;
    disable iff (1'h0) reset |=> !chip_clk_stop && !trigger_out && !clock_stretch;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared");
  property p_ext;
    $rose(external_trigger_input) |-> ##[1:270] chip_clk_stop;
  endproperty
  a_ext: assert property (p_ext) else $error("external stop missing");
endmodule
bind der_top der_top_checker u_chk (.clk(clk), .reset(reset), .csr_wr(csr_wr),
  .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
  .csr_rvalid(csr_rvalid), .chip_clk_stop(chip_clk_stop), .clock_stretch(clock_stretch),
  .trigger_out(trigger_out), .external_trigger_input(external_trigger_input));

//--- verification/tb_der_top.sv
// self-checking bench for the debug event response block
`timescale 1ns/1ps
module tb_der_top;
  localparam int N = 8;
  logic clk, reset, por_done, go, csr_wr, csr_rd, ext_trig, csr_rvalid;
  logic chip_clk_stop, clock_stretch, trigger_out, sys_hard_req, sys_watch_req;
  logic [2:0] kind, jl;
  logic [N-1:0] sel, ext_domain_stop, strand_running, core_clk_stop, strand_quiesced;
  logic [N-1:0] core_soft_req, core_hard_req, core_watch_req;
  logic [7:0] ext_stop_delay;
  logic [der_pkg::ADDR_W-1:0] csr_addr;
  logic [63:0] jtag_data, csr_wdata, csr_rdata;
  int bad_count, checks, tc, sc, a;
  der_top #(.NUM_CORES(N), .DELAY_W(8)) DUT (.clk(clk), .reset(reset), .por_done(por_done),
    .core_soft_req(core_soft_req), .core_hard_req(core_hard_req),
    .core_watch_req(core_watch_req), .sys_hard_req(sys_hard_req),
    .sys_watch_req(sys_watch_req), .strand_quiesced(strand_quiesced),
    .external_trigger_input(ext_trig), .ext_stop_delay(ext_stop_delay),
    .ext_domain_stop(ext_domain_stop), .jtag_load_event_tally(jl[0]),
    .jtag_load_cycle_count(jl[1]), .jtag_load_response_control(jl[2]),
    .jtag_data(jtag_data), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .strand_running(strand_running), .core_clk_stop(core_clk_stop),
    .chip_clk_stop(chip_clk_stop), .clock_stretch(clock_stretch), .trigger_out(trigger_out));
  der_req_model #(.N(N)) u_req (.clk(clk), .go(go), .kind(kind), .sel(sel),
    .strand_running(strand_running), .core_soft_req(core_soft_req),
    .core_hard_req(core_hard_req), .core_watch_req(core_watch_req),
    .sys_hard_req(sys_hard_req), .sys_watch_req(sys_watch_req),
    .strand_quiesced(strand_quiesced));
  // core clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [der_pkg::ADDR_W-1:0] ad, input logic [63:0] d);
    csr_addr = ad;
    csr_wdata = d;
    csr_wr = 1'h1;
    cyc(1);
    csr_wr = 1'h0;
  endtask
  // next read only after data returned
  task automatic rd(input logic [der_pkg::ADDR_W-1:0] ad, input logic [63:0] e);
    csr_addr = ad;
    csr_rd = 1'h1;
    cyc(1);
    csr_rd = 1'h0;
    chk("rvalid", 64'h1, 64'(csr_rvalid));
    chk("rdata", e, csr_rdata);
    cyc(1);
  endtask
  task automatic jt(input int k, input logic [63:0] d);
    jtag_data = d;
    jl[k] = 1'h1;
    cyc(1);
    jl[k] = 1'h0;
  endtask
  task automatic req(input logic [2:0] k, input logic [N-1:0] s);
    kind = k;
    sel = s;
    go = 1'h1;
    cyc(1);
    go = 1'h0;
  endtask
  task automatic rst();
    reset = 1'h1;
    cyc(12);
    reset = 1'h0;
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clk);
      tc += int'(trigger_out === 1'h1);
      sc += int'(clock_stretch === 1'h1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    cyc(3000);
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    {por_done, go, csr_wr, csr_rd, ext_trig, kind, jl, sel} = '0;
    {csr_addr, csr_wdata, jtag_data} = '0;
    ext_stop_delay = 8'h04;
    ext_domain_stop = 8'h05;
    rst();
    rd(der_pkg::OFS_TALLY, 64'h0);
    rd(der_pkg::OFS_CYCLE, 64'h0);
    rd(der_pkg::OFS_CTRL, 64'h0);
    rd(44'h000_0000_0FF0, 64'h0);
    wr(der_pkg::OFS_TRIG, 64'h1);
    chk("trig", 64'h1, 64'(trigger_out));
    cyc(1);
    chk("trig_end", 64'h0, 64'(trigger_out));
    rd(der_pkg::OFS_TRIG, 64'h0);
    wr(der_pkg::OFS_TALLY, 64'h6);
    req(3'h2, 8'h03);
    rd(der_pkg::OFS_TALLY, 64'h4);
    req(3'h3, 8'h00);
    rd(der_pkg::OFS_TALLY, 64'h0);
    chk("consumed", 64'h0, 64'(chip_clk_stop));
    req(3'h4, 8'h00);
    chk("swatch", 64'h1, 64'(trigger_out));
    jt(2, 64'h4);
    jt(0, 64'h3);
    req(3'h0, 8'h01);
    rd(der_pkg::OFS_TALLY, 64'h3);
    jt(2, 64'h0);
    jt(0, 64'h0);
    wr(der_pkg::OFS_CYCLE, 64'h8);
    req(3'h1, 8'h10);
    cyc(4);
    chk("early", 64'h0, 64'(chip_clk_stop));
    cyc(4);
    chk("late", 64'h0, 64'(chip_clk_stop));
    cyc(1);
    chk("stop", 64'h1, 64'(chip_clk_stop));
    cyc(1);
    chk("cores", 64'hFF, 64'(core_clk_stop));
    rst();
    jt(2, 64'h8);
    req(3'h0, 8'h04);
    cyc(4);
    chk("run", 64'h0, 64'(strand_running));
    chk("wait", 64'h0, 64'(core_clk_stop));
    cyc(8);
    chk("soft", 64'hFF, 64'(core_clk_stop));
    for (a = 0; a < 4; a++) begin
      rst();
      por_done = 1'h0;
      jt(1, 64'h0000_0003_0000_0005);
      jt(2, 64'(4 + a));
      tc = 0;
      sc = 0;
      watch(10);
      chk("por", 64'h0, 64'(tc));
      por_done = 1'h1;
      watch(30);
      chk("pulses", (a == 3) ? 64'h2 : 64'h1, 64'(tc));
      chk("stretch", 64'((a >> 1) & 1), 64'(sc));
      chk("hard", 64'(a & 1), 64'(chip_clk_stop));
    end
    rst();
    ext_trig = 1'h1;
    cyc(3);
    chk("xearly", 64'h0, 64'(chip_clk_stop));
    cyc(4);
    chk("xdelay", 64'h0, 64'(chip_clk_stop));
    cyc(1);
    chk("xstop", 64'h1, 64'(chip_clk_stop));
    cyc(1);
    chk("xdom", 64'h05, 64'(core_clk_stop));
    conclude();
  end
endmodule
